/* File: cmr_cfg.svh */
/*
  Constants for the CAN mode and register control block: SPI op-codes,
  field positions, reset values and recovery counts.
  Assumes inclusion by cmr_pkg.sv and cmr_mode_ctrl.sv.
*/
`ifndef CMR_CFG_SVH
`define CMR_CFG_SVH

// Write op-codes
`define CMR_WR_MAIN   8'h14
`define CMR_WR_TXC    8'h16
`define CMR_WR_BTA    8'h18
`define CMR_WR_BTB    8'h1a
`define CMR_WR_TEC    8'h26
`define CMR_WR_REC    8'h24
`define CMR_WR_INTERRUPT_ENABLES   8'h1c
`define CMR_WR_STATUS_FLAG_ENABLES 8'h1e
`define CMR_WR_AUX    8'h22
// Read op-codes
`define CMR_RD_MAIN   8'hd2
`define CMR_RD_TXC    8'hd4
`define CMR_RD_BTA    8'hd6
`define CMR_RD_BTB    8'hd8
`define CMR_RD_TEC    8'hec
`define CMR_RD_REC    8'hea
`define CMR_RD_MSTAT  8'hda
`define CMR_RD_ERR    8'hdc
`define CMR_RD_INTERRUPT_FLAGS   8'hde
`define CMR_RD_INTERRUPT_ENABLES   8'he4
`define CMR_RD_STATUS_FLAGS  8'he2
`define CMR_RD_STATUS_FLAG_ENABLES 8'he6
`define CMR_RD_AUX    8'he8
`define CMR_RD_TIMER  8'hfa
// Master reset command
`define CMR_OP_RESET  8'h56

// main_control fields
`define CMR_MODE_HI   7
`define CMR_MODE_LO   5
`define CMR_WAKE_EN   4
`define CMR_SWRST     3
`define CMR_BOR       2
`define CMR_TDIV_HI   1
`define CMR_TDIV_LO   0
`define CMR_MAIN_RST  8'h80

// Wake flag and its enable
`define CMR_WAKE_FLAG 7
`define CMR_WAKE_IE   7

// Bus-off recovery: 128 runs of 11 recessive bits
`define CMR_RUN_LEN   11
`define CMR_RUN_SEQS  128
`define CMR_RUN_LAST  (4'(`CMR_RUN_LEN - 1))
`define CMR_SEQ_LAST  (7'(`CMR_RUN_SEQS - 1))

`endif

/* File: cmr_pkg.sv */
/*
  Types for the CAN mode and register control block.
  Assumes cmr_cfg.svh is on the include path.
*/
`include "cmr_cfg.svh"

package cmr_pkg;

  typedef enum logic [2:0] {
    CMR_MODE_NORMAL = 3'b000,
    CMR_MODE_LOOP   = 3'b001,
    CMR_MODE_MON    = 3'b010,
    CMR_MODE_SLEEP  = 3'b011,
    CMR_MODE_INIT   = 3'b100
  } cmr_mode_e;

  typedef enum logic [1:0] {
    CMR_SPI_OP = 2'b00,
    CMR_SPI_WR = 2'b01,
    CMR_SPI_RD = 2'b10
  } cmr_spi_e;

  // Host-written settings handed to the protocol engine
  typedef struct packed {
    logic [7:0] transmit_control;
    logic [7:0] bit_timing_a;
    logic [7:0] bit_timing_b;
    logic [7:0] transmit_error_count;
    logic [7:0] receive_error_count;
    logic [7:0] interrupt_enables;
    logic [7:0] status_flag_enables;
    logic [7:0] aux_pin_enables;
  } cmr_cfg_s;

  // Status from the protocol engine; int_flags bit 7 is unused
  typedef struct packed {
    logic [7:0] message_status;
    logic [7:0] error_status;
    logic [7:0] int_flags;
    logic [7:0] status_flags;
  } cmr_stat_s;

endpackage : cmr_pkg

/* File: cmr_mode_ctrl.sv */
/*
  SPI register file and operating-mode control of a CAN controller:
  mode selection, sleep and wake-up, master reset, bus-off recovery
  and the time-tag counter.
  Assumes SPI mode 0 with SCK well below a quarter of clk, and a
  protocol engine on clk that supplies bit_tick and status.
*/
// Summary of operation
// [R1] - Bits active high, bit 7 is MSB
// [R2] - Master reset clears registers to zero
// [R3] - Timer read whole: upper then lower byte
// [R4] - Power-on runs master reset, enters init
// [R5] - Mode field selects normal/loop/monitor/sleep/init
// [R6] - Loopback feeds transmit to receiver, bus quiet
// [R7] - Monitor never drives ack or error
// [R8] - Sleep only when bus idle, FIFO empty
// [R9] - Host leaves sleep by writing new mode
// [R10] - Wake enable plus bus activity: to monitor
// [R11] - Wake sets flag; interrupt if enabled
// [R12] - Wake disabled: sleep ignores bus activity
// [R13] - Bit timing writable only in init mode
// [R14] - Software reset bit acts as reset pin
// [R15] - Host rewrites control to clear reset bit
// [R16] - Reset command byte causes master reset
// [R17] - Auto recovery after 128 recessive runs
// [R18] - Without auto recovery host recovers bus-off
// [R19] - Divider sets time-tag rate 1/2/4/8
// [R20] - Status and timer registers are read-only
// [R21] - Bit timing b has write and read codes
// [R22] - Transmit error count writable and readable
`timescale 1ns/1ps
`default_nettype none
`include "cmr_cfg.svh"

module cmr_mode_ctrl
  import cmr_pkg::*;
(
  // Clock and reset
  input  wire logic      clk,
  input  wire logic      rst_n,
  // SPI pins
  input  wire logic      spi_sck,
  input  wire logic      spi_cs_n,
  input  wire logic      spi_mosi,
  output logic           spi_miso,
  output logic           spi_miso_oe_n,
  // Reset pin
  input  wire logic      master_reset_pin,
  // CAN bus side
  input  wire logic      can_rx,
  output logic           can_tx,
  // Protocol engine side
  input  wire logic      core_tx,
  output logic           core_rx,
  input  wire logic      bit_tick,
  input  wire logic      bus_idle,
  input  wire logic      tx_fifo_empty,
  input  wire logic      bus_off,
  input  wire cmr_stat_s core_stat,
  output cmr_cfg_s       cfg,
  output cmr_mode_e      mode,
  output logic           core_reset,
  output logic           busoff_recover,
  output logic           irq
);

  // Pin synchronisers: {sck, cs_n, mosi, rx, mr}
  logic [4:0]  sync1;
  logic [4:0]  sync2;
  logic        sck_prev;
  logic        rx_prev;
  logic        sck_s;
  logic        cs_s;
  logic        mosi_s;
  logic        rx_s;
  logic        mr_s;

  logic [7:0]  main_control;
  logic [6:0]  rx_sh;
  logic [2:0]  bit_cnt;
  logic [15:0] tx_sh;
  logic [15:0] rd_word;
  cmr_spi_e    spi_st;
  logic [7:0]  opcode;
  logic        wake_flag;
  logic [2:0]  div_cnt;
  logic [2:0]  div_mask;
  logic [15:0] time_tag;
  logic [3:0]  run_cnt;
  logic [6:0]  seq_cnt;

  logic        sck_rise;
  logic        sck_fall;
  logic        rx_fall;
  logic        byte_done;
  logic [7:0]  byte_val;
  logic        op_stb;
  logic        wr_stb;
  logic        mr_hard;
  logic        mr_act;
  logic        sleep_bad;
  logic        wake_evt;
  logic        tag_adv;
  logic        run_end;
  logic [7:0]  int_flags;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1 <= 5'h0e;
      sync2 <= 5'h0e;
    end else begin
      sync1 <= {spi_sck, spi_cs_n, spi_mosi, can_rx, master_reset_pin};
      sync2 <= sync1;
    end
  end

  assign {sck_s, cs_s, mosi_s, rx_s, mr_s} = sync2;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sck_prev <= 1'b0;
      rx_prev  <= 1'b1;
    end else begin
      sck_prev <= sck_s;
      rx_prev  <= rx_s;
    end
  end

  assign sck_rise  = sck_s & ~sck_prev & ~cs_s;
  assign sck_fall  = ~sck_s & sck_prev & ~cs_s;
  assign rx_fall   = rx_prev & ~rx_s;
  assign byte_done = sck_rise && (bit_cnt == 3'd7);
  assign byte_val  = {rx_sh, mosi_s};
  assign op_stb    = byte_done && (spi_st == CMR_SPI_OP);
  assign wr_stb    = byte_done && (spi_st == CMR_SPI_WR);

  // Bytes arrive MSB first [R1]
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_sh   <= 7'h00;
      bit_cnt <= 3'd0;
    end else if (cs_s) begin
      bit_cnt <= 3'd0;
    end else if (sck_rise) begin
      rx_sh   <= byte_val[6:0];
      bit_cnt <= bit_cnt + 3'd1;
    end
  end

  function automatic logic is_wr_op(input logic [7:0] op);
    case (op)
      `CMR_WR_MAIN, `CMR_WR_TXC, `CMR_WR_BTA, `CMR_WR_BTB,
      `CMR_WR_TEC, `CMR_WR_REC, `CMR_WR_INTERRUPT_ENABLES, `CMR_WR_STATUS_FLAG_ENABLES,
      `CMR_WR_AUX: is_wr_op = 1'b1;
      default:     is_wr_op = 1'b0;
    endcase
  endfunction : is_wr_op

  // Only one data byte per write; extra bytes are dropped
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      spi_st <= CMR_SPI_OP;
      opcode <= 8'h00;
    end else if (cs_s) begin
      spi_st <= CMR_SPI_OP;
    end else if (op_stb) begin
      opcode <= byte_val;
      spi_st <= is_wr_op(byte_val) ? CMR_SPI_WR : CMR_SPI_RD;
    end else if (wr_stb) begin
      spi_st <= CMR_SPI_RD;
    end
  end

  assign int_flags = {wake_flag, core_stat.int_flags[6:0]};

  always_comb begin
    rd_word = 16'h0000;
    case (byte_val)
      `CMR_RD_MAIN:   rd_word[15:8] = main_control;
      `CMR_RD_TXC:    rd_word[15:8] = cfg.transmit_control;
      `CMR_RD_BTA:    rd_word[15:8] = cfg.bit_timing_a;
      `CMR_RD_BTB:    rd_word[15:8] = cfg.bit_timing_b;         // [R21]
      `CMR_RD_TEC:    rd_word[15:8] = cfg.transmit_error_count; // [R22]
      `CMR_RD_REC:    rd_word[15:8] = cfg.receive_error_count;
      `CMR_RD_MSTAT:  rd_word[15:8] = core_stat.message_status; // [R20]
      `CMR_RD_ERR:    rd_word[15:8] = core_stat.error_status;   // [R20]
      `CMR_RD_INTERRUPT_FLAGS:   rd_word[15:8] = int_flags;                // [R20]
      `CMR_RD_INTERRUPT_ENABLES:   rd_word[15:8] = cfg.interrupt_enables;
      `CMR_RD_STATUS_FLAGS:  rd_word[15:8] = core_stat.status_flags;   // [R20]
      `CMR_RD_STATUS_FLAG_ENABLES: rd_word[15:8] = cfg.status_flag_enables;
      `CMR_RD_AUX:    rd_word[15:8] = cfg.aux_pin_enables;
      `CMR_RD_TIMER:  rd_word = time_tag;                       // [R3]
      default:        rd_word = 16'h0000;
    endcase
  end

  // Both timer bytes are captured together so the pair is coherent
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_sh    <= 16'h0000;
      spi_miso <= 1'b0;
    end else if (cs_s) begin
      tx_sh    <= 16'h0000;
      spi_miso <= 1'b0;
    end else if (op_stb) begin
      tx_sh    <= rd_word; // [R3]
    end else if (sck_fall) begin
      spi_miso <= tx_sh[15]; // [R1]
      tx_sh    <= {tx_sh[14:0], 1'b0};
    end
  end

  assign spi_miso_oe_n = cs_s;

  // Master reset sources [R14] [R16]
  assign mr_hard    = mr_s | (op_stb && (byte_val == `CMR_OP_RESET));
  assign mr_act     = mr_hard | main_control[`CMR_SWRST];
  assign core_reset = mr_act;

  // Mode field [R5]; the reset bit also forces init
  assign mode = (main_control[`CMR_MODE_HI] || main_control[`CMR_SWRST])
              ? CMR_MODE_INIT
              : cmr_mode_e'(main_control[`CMR_MODE_HI:`CMR_MODE_LO]);

  assign sleep_bad = (byte_val[`CMR_MODE_HI:`CMR_MODE_LO] == CMR_MODE_SLEEP)
                  && !(bus_idle && tx_fifo_empty);

  assign wake_evt = (mode == CMR_MODE_SLEEP) && rx_fall && !mr_act
                 && main_control[`CMR_WAKE_EN]; // [R12]

  // main_control survives its own reset bit so the host can clear it
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      main_control <= `CMR_MAIN_RST; // [R4]
    end else if (mr_hard) begin
      main_control <= `CMR_MAIN_RST; // [R14] [R16]
    end else if (wr_stb && opcode == `CMR_WR_MAIN) begin
      main_control[`CMR_MODE_LO-1:0] <= byte_val[`CMR_MODE_LO-1:0];
      if (!sleep_bad) begin
        main_control[`CMR_MODE_HI:`CMR_MODE_LO] <=
          byte_val[`CMR_MODE_HI:`CMR_MODE_LO]; // [R8] [R9] [R15]
      end
    end else if (wake_evt) begin
      main_control[`CMR_MODE_HI:`CMR_MODE_LO] <= CMR_MODE_MON; // [R10]
    end else if (busoff_recover) begin
      main_control[`CMR_MODE_HI:`CMR_MODE_LO] <= CMR_MODE_NORMAL; // [R17]
    end
  end

  // Register file cleared by any master reset [R2]
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg <= '0;
    end else if (mr_act) begin
      cfg <= '0; // [R2]
    end else if (busoff_recover) begin
      cfg.transmit_error_count <= 8'h00; // [R17]
      cfg.receive_error_count  <= 8'h00;
    end else if (wr_stb) begin
      case (opcode)
        `CMR_WR_TXC:    cfg.transmit_control <= byte_val;
        `CMR_WR_BTA: begin
          if (mode == CMR_MODE_INIT) cfg.bit_timing_a <= byte_val; // [R13]
        end
        `CMR_WR_BTB: begin
          if (mode == CMR_MODE_INIT) cfg.bit_timing_b <= byte_val; // [R21]
        end
        `CMR_WR_TEC:    cfg.transmit_error_count <= byte_val; // [R22]
        `CMR_WR_REC:    cfg.receive_error_count  <= byte_val;
        `CMR_WR_INTERRUPT_ENABLES:   cfg.interrupt_enables    <= byte_val;
        `CMR_WR_STATUS_FLAG_ENABLES: cfg.status_flag_enables  <= byte_val;
        `CMR_WR_AUX:    cfg.aux_pin_enables      <= byte_val;
        default:        cfg <= cfg;
      endcase
    end
  end

  // Wake flag, cleared by reading the flag register; a set wins
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wake_flag <= 1'b0;
    end else if (mr_act) begin
      wake_flag <= 1'b0;
    end else if (wake_evt) begin
      wake_flag <= 1'b1; // [R11]
    end else if (op_stb && byte_val == `CMR_RD_INTERRUPT_FLAGS) begin
      wake_flag <= 1'b0;
    end
  end

  assign irq = |(int_flags & cfg.interrupt_enables); // [R11]

  // Bus pin: only normal mode lets the engine drive [R6] [R7]
  assign can_tx  = (mode == CMR_MODE_NORMAL) ? core_tx : 1'b1;
  assign core_rx = (mode == CMR_MODE_LOOP) ? core_tx : rx_s; // [R6]

  // Time-tag counter with power-of-two divider [R19]
  assign div_mask = 3'((4'h1 << main_control[`CMR_TDIV_HI:`CMR_TDIV_LO])
                    - 4'h1);
  assign tag_adv  = bit_tick && ((div_cnt & div_mask) == div_mask);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div_cnt  <= 3'd0;
      time_tag <= 16'h0000;
    end else if (mr_act) begin
      div_cnt  <= 3'd0;
      time_tag <= 16'h0000;
    end else if (bit_tick) begin
      div_cnt <= tag_adv ? 3'd0 : div_cnt + 3'd1;
      if (tag_adv) time_tag <= time_tag + 16'h0001; // [R19]
    end
  end

  // Recessive-run counting while bus-off with auto recovery [R17]
  assign run_end = bit_tick && rx_s && (run_cnt == `CMR_RUN_LAST);
  assign busoff_recover = bus_off && main_control[`CMR_BOR] && !mr_act
                       && run_end && (seq_cnt == `CMR_SEQ_LAST);

  // Without the bit set nothing counts; the host recovers [R18]
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      run_cnt <= 4'd0;
      seq_cnt <= 7'd0;
    end else if (!bus_off || !main_control[`CMR_BOR] || mr_act) begin
      run_cnt <= 4'd0;
      seq_cnt <= 7'd0;
    end else if (bit_tick) begin
      if (!rx_s) begin
        run_cnt <= 4'd0;
      end else if (run_end) begin
        run_cnt <= 4'd0;
        seq_cnt <= seq_cnt + 7'd1; // [R17]
      end else begin
        run_cnt <= run_cnt + 4'd1;
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_wake_cause;
    mode == CMR_MODE_SLEEP && main_control[`CMR_WAKE_EN] && rx_fall
    && !mr_act && !wr_stb;
  endsequence

  sequence s_woken;
    mode == CMR_MODE_MON && wake_flag;
  endsequence

  a_wake_to_mon: assert property (s_wake_cause |=> s_woken) // [R10]
    else $error("wake-up did not reach monitor with flag");

  a_wake_irq: assert property (
    wake_evt && cfg.interrupt_enables[`CMR_WAKE_IE] |=> irq) // [R11]
    else $error("enabled wake did not raise irq");

  a_sleep_hold: assert property (
    mode == CMR_MODE_SLEEP && !main_control[`CMR_WAKE_EN] && !wr_stb
    && !mr_act |=> mode == CMR_MODE_SLEEP) // [R12]
    else $error("sleep left without host or wake");

  a_sleep_guard: assert property (
    mode != CMR_MODE_SLEEP ##1 mode == CMR_MODE_SLEEP
    |-> $past(bus_idle) && $past(tx_fifo_empty)) // [R8]
    else $error("sleep entered while bus busy");

  a_reset_init: assert property (mr_hard |=> mode == CMR_MODE_INIT
    && cfg == '0 ##1 mode == CMR_MODE_INIT) // [R4]
    else $error("master reset did not force init");

  a_swrst_clear: assert property (
    main_control[`CMR_SWRST] |=> cfg == '0 && time_tag == 16'h0000) // [R14]
    else $error("reset bit did not clear registers");

  a_bt_lock: assert property (
    mode != CMR_MODE_INIT && !mr_act |=> $stable(cfg.bit_timing_a)
    && $stable(cfg.bit_timing_b)) // [R13]
    else $error("bit timing changed outside init");

  a_quiet_bus: assert property (
    mode inside {CMR_MODE_LOOP, CMR_MODE_MON} |-> can_tx) // [R7]
    else $error("bus driven in loopback or monitor");

  a_loop_path: assert property (
    mode == CMR_MODE_LOOP |-> core_rx == core_tx) // [R6]
    else $error("loopback path broken");

  a_tag_step: assert property (
    bit_tick && main_control[1:0] == 2'b00 && !mr_act
    |=> time_tag == $past(time_tag) + 16'h0001) // [R19]
    else $error("time tag did not advance");

  a_recover_on: assert property (
    busoff_recover |=> mode == CMR_MODE_NORMAL
    && cfg.transmit_error_count == 8'h00) // [R17]
    else $error("bus-off recovery incomplete");

endmodule : cmr_mode_ctrl

`default_nettype wire

/* File: cmr_spi_host.sv */
/*
  Host model: drives the register port as an SPI mode 0 master.
  Assumes the bench calls xfer just after a rising edge of clk.
*/
`timescale 1ns/1ps
`default_nettype none

module cmr_spi_host (
  // Clock
  input  wire logic clk,
  // SPI pins
  input  wire logic miso,
  output var  logic sck,
  output var  logic cs_n,
  output var  logic mosi
);
  // Six clocks per SCK phase covers the device's three-clock sync delay
  localparam int HALF = 6;

  initial begin
    sck  = 1'b0;
    cs_n = 1'b1;
    mosi = 1'b1;
  end

  // MSB first; MISO is taken at the edge that raises SCK
  task automatic put_byte(input logic [7:0] b, inout logic [15:0] r);
    for (int i = 7; i >= 0; i--) begin
      mosi <= b[i];
      repeat (HALF) @(posedge clk);
      sck <= 1'b1;
      r = {r[14:0], miso};
      repeat (HALF) @(posedge clk);
      sck <= 1'b0;
    end
  endtask : put_byte

  // Op byte, then nb data bytes: wd first, zeros after
  task automatic xfer(input logic [7:0] op, input logic [7:0] wd,
                      input int nb, output logic [15:0] r);
    r = 16'h0000;
    cs_n <= 1'b0;
    repeat (HALF) @(posedge clk);
    put_byte(op, r);
    for (int k = 0; k < nb; k++) begin
      put_byte((k == 0) ? wd : 8'h00, r);
    end
    repeat (HALF) @(posedge clk);
    cs_n <= 1'b1;
    repeat (2 * HALF) @(posedge clk);
  endtask : xfer
endmodule : cmr_spi_host

`default_nettype wire

/* File: cmr_mode_ctrl_tb.sv */
/*
  Self-checking bench for cmr_mode_ctrl: register map, modes, sleep
  and wake, resets, time tag and bus-off recovery.
  Assumes cmr_pkg.sv and cmr_spi_host.sv are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
`include "cmr_cfg.svh"

module cmr_mode_ctrl_tb
  import cmr_pkg::*;
();
  logic        clk, rst_n, master_reset_pin, can_rx, core_tx, bit_tick;
  logic        bus_idle, tx_fifo_empty, bus_off;
  logic        sck, cs_n, mosi, miso, miso_oe_n, miso_w;
  logic        can_tx, core_rx, core_reset, busoff_recover, irq;
  cmr_stat_s   core_stat;
  cmr_cfg_s    cfg;
  cmr_mode_e   mode;
  int          mismatches, total_checks, rec_cnt;
  logic [15:0] r, t0;
  logic [7:0]  wr_op [8] = '{8'h16, 8'h18, 8'h1a, 8'h26, 8'h24, 8'h1c,
                             8'h1e, 8'h22};
  logic [7:0]  rd_op [8] = '{8'hd4, 8'hd6, 8'hd8, 8'hec, 8'hea, 8'he4,
                             8'he6, 8'he8};
  logic [7:0]  mv [4] = '{8'h00, 8'h20, 8'h40, 8'ha0};

  // A released MISO shows the inverse so a stale bit cannot pass
  assign miso_w = miso_oe_n ? ~miso : miso;

  cmr_spi_host host_u (.clk(clk), .miso(miso_w), .sck(sck), .cs_n(cs_n),
                       .mosi(mosi));

  cmr_mode_ctrl dut_u (.clk(clk), .rst_n(rst_n), .spi_sck(sck),
    .spi_cs_n(cs_n), .spi_mosi(mosi), .spi_miso(miso),
    .spi_miso_oe_n(miso_oe_n), .master_reset_pin(master_reset_pin),
    .can_rx(can_rx), .can_tx(can_tx), .core_tx(core_tx), .core_rx(core_rx),
    .bit_tick(bit_tick), .bus_idle(bus_idle), .tx_fifo_empty(tx_fifo_empty),
    .bus_off(bus_off), .core_stat(core_stat), .cfg(cfg), .mode(mode),
    .core_reset(core_reset), .busoff_recover(busoff_recover), .irq(irq));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  always @(posedge clk) begin
    if (busoff_recover === 1'b1) rec_cnt++;
  end

  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : stop_test

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic wr(input logic [7:0] op, input logic [7:0] d);
    host_u.xfer(op, d, 1, r);
  endtask : wr

  task automatic rd_chk(input logic [7:0] op, input logic [7:0] exp);
    host_u.xfer(op, 8'h00, 1, r);
    check(16'(r[7:0]), 16'(exp));
  endtask : rd_chk

  task automatic ticks(input int n);
    repeat (n) begin
      bit_tick <= 1'b1;
      @(posedge clk);
      bit_tick <= 1'b0;
      @(posedge clk);
    end
  endtask : ticks

  // Hang guard, about two and a half times the expected run
  initial begin
    repeat (60000) @(posedge clk);
    mismatches++;
    stop_test();
  end

  initial begin
    {rst_n, master_reset_pin, bit_tick, bus_off, core_tx} = 5'b00000;
    {can_rx, bus_idle, tx_fifo_empty} = 3'b111;
    core_stat = '0;
    {mismatches, total_checks, rec_cnt} = 96'h0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    check(16'(mode), 16'(CMR_MODE_INIT));
    check(16'(miso_oe_n), 16'h0001);
    rd_chk(`CMR_RD_MAIN, `CMR_MAIN_RST);
    foreach (rd_op[i]) rd_chk(rd_op[i], 8'h00);
    core_stat <= 32'ha1b243d4;
    rd_chk(`CMR_RD_MSTAT, 8'ha1);
    rd_chk(`CMR_RD_ERR, 8'hb2);
    rd_chk(`CMR_RD_INTERRUPT_FLAGS, 8'h43);
    rd_chk(`CMR_RD_STATUS_FLAGS, 8'hd4);
    rd_chk(8'hf0, 8'h00);
    core_stat <= '0;
    for (int i = 0; i < 8; i++) begin
      wr(wr_op[i], 8'h80 | 8'(i));
      rd_chk(rd_op[i], 8'h80 | 8'(i));
    end
    check(16'(cfg.bit_timing_b), 16'h0082);
    wr(`CMR_WR_INTERRUPT_ENABLES, 8'h00);
    for (int m = 0; m < 4; m++) begin
      wr(`CMR_WR_MAIN, mv[m]);
      check(16'(mode), (m < 3) ? 16'(m) : 16'h0004);
      check(16'(can_tx), (m == 0) ? 16'h0000 : 16'h0001);
      check(16'(core_rx), (m == 1) ? 16'h0000 : 16'h0001);
      rd_chk(`CMR_RD_MAIN, mv[m]);
    end
    wr(`CMR_WR_MAIN, 8'h00);
    wr(`CMR_WR_BTA, 8'h33);
    rd_chk(`CMR_RD_BTA, 8'h81);
    for (int k = 0; k < 2; k++) begin
      {bus_idle, tx_fifo_empty} <= (k == 0) ? 2'b01 : 2'b10;
      wr(`CMR_WR_MAIN, 8'h60);
      check(16'(mode), 16'(CMR_MODE_NORMAL));
    end
    {bus_idle, tx_fifo_empty} <= 2'b11;
    wr(`CMR_WR_MAIN, 8'h60);
    check(16'(mode), 16'(CMR_MODE_SLEEP));
    can_rx <= 1'b0;
    repeat (8) @(posedge clk);
    check(16'(mode), 16'(CMR_MODE_SLEEP));
    can_rx <= 1'b1;
    wr(`CMR_WR_MAIN, 8'h00);
    check(16'(mode), 16'(CMR_MODE_NORMAL));
    wr(`CMR_WR_MAIN, 8'h70);
    can_rx <= 1'b0;
    repeat (8) @(posedge clk);
    check(16'(mode), 16'(CMR_MODE_MON));
    check(16'(irq), 16'h0000);
    can_rx <= 1'b1;
    wr(`CMR_WR_INTERRUPT_ENABLES, 8'h80);
    check(16'(irq), 16'h0001);
    rd_chk(`CMR_RD_INTERRUPT_FLAGS, 8'h80);
    check(16'(irq), 16'h0000);
    for (int d = 0; d < 4; d++) begin
      wr(`CMR_WR_MAIN, 8'(d));
      host_u.xfer(`CMR_RD_TIMER, 8'h00, 2, t0);
      ticks(16);
      host_u.xfer(`CMR_RD_TIMER, 8'h00, 2, r);
      check(r - t0, 16'd16 >> d);
    end
    // Auto recovery off first, where nothing recovers, then the automatic one
    wr(`CMR_WR_TEC, 8'h10);
    for (int b = 0; b < 2; b++) begin
      wr(`CMR_WR_MAIN, (b == 1) ? 8'h44 : 8'h40);
      // Let the dominant bit pass the synchroniser before its tick
      {bus_off, can_rx} <= 2'b10;
      repeat (3) @(posedge clk);
      ticks(1);
      can_rx <= 1'b1;
      repeat (3) @(posedge clk);
      ticks(128 * 11 - 1);
      check(16'(rec_cnt), 16'h0000);
      ticks(1);
      repeat (3) @(posedge clk);
      check(16'(rec_cnt), 16'(b));
    end
    check(16'(mode), 16'(CMR_MODE_NORMAL));
    rd_chk(`CMR_RD_TEC, 8'h00);
    rd_chk(`CMR_RD_REC, 8'h00);
    bus_off <= 1'b0;
    wr(`CMR_WR_MAIN, 8'h80);
    wr(`CMR_WR_BTB, 8'h5a);
    wr(`CMR_WR_MAIN, 8'h88);
    check(16'(mode), 16'(CMR_MODE_INIT));
    check(16'(core_reset), 16'h0001);
    rd_chk(`CMR_RD_BTB, 8'h00);
    wr(`CMR_WR_MAIN, 8'h80);
    check(16'(core_reset), 16'h0000);
    wr(`CMR_WR_BTB, 8'h5a);
    host_u.xfer(`CMR_OP_RESET, 8'h00, 0, r);
    rd_chk(`CMR_RD_BTB, 8'h00);
    wr(`CMR_WR_BTB, 8'h5a);
    wr(`CMR_WR_MAIN, 8'h00);
    master_reset_pin <= 1'b1;
    repeat (4) @(posedge clk);
    check(16'(core_reset), 16'h0001);
    master_reset_pin <= 1'b0;
    repeat (4) @(posedge clk);
    check(16'(mode), 16'(CMR_MODE_INIT));
    rd_chk(`CMR_RD_MAIN, `CMR_MAIN_RST);
    rd_chk(`CMR_RD_BTB, 8'h00);
    stop_test();
  end
endmodule : cmr_mode_ctrl_tb

`default_nettype wire
